// ### rtl/dia_consts.vh
// Constants for the dual interface access arbiter.
//=====================================================================
// Functional notes
// - Contact two-wire port wins contention, except over a launched RF write cycle.
// - After a two-wire command is received, later RF commands are ignored until done.
// - Two-wire command during RF command before its write cycle aborts the RF operation.
// - Two-wire command during an RF write cycle waits unanswered until the cycle ends.
// - Contact transaction is released by timeout no earlier than 40 ms after start.
// - SCL low or high phase beyond 20000 us is a timeout; transaction abandoned.
// - Harvest/field-detect output follows the RF field; RF activity output shows RF port activity.
// - Voltage select codes 00,01,10,11 give 1.5, 1.8, 2.5, 3.3 V.
// - Current limit codes 00,01,10,11 give no limit, 2, 1, 0.5 mA.
`ifndef DIA_CONSTS_VH
`define DIA_CONSTS_VH

//=====================================================================
// Timing
`define DIA_CLK_MHZ 100
`define DIA_START_TO_MS 40
`define DIA_PHASE_TO_US 20000
`define DIA_WR_CYCLE_MS 5
`define DIA_START_TO_CYC (`DIA_START_TO_MS * 1000 * `DIA_CLK_MHZ)
`define DIA_PHASE_TO_CYC (`DIA_PHASE_TO_US * `DIA_CLK_MHZ)
`define DIA_WR_CYC (`DIA_WR_CYCLE_MS * 1000 * `DIA_CLK_MHZ)
`define DIA_CNT_W 23

//=====================================================================
// Owner states
`define DIA_ST_IDLE 3'h0
`define DIA_ST_TW 3'h1
`define DIA_ST_TW_WR 3'h2
`define DIA_ST_RF 3'h3
`define DIA_ST_RF_WR 3'h4

//=====================================================================
// Harvest codes
`define DIA_EHV_1V5 2'h0
`define DIA_EHV_1V8 2'h1
`define DIA_EHV_2V5 2'h2
`define DIA_EHV_3V3 2'h3
`define DIA_EHI_NONE 2'h0
`define DIA_EHI_2MA 2'h1
`define DIA_EHI_1MA 2'h2
`define DIA_EHI_0MA5 2'h3

`endif

// ### rtl/dia_tw_monitor.v
// Two-wire bus watcher: start/stop detection and phase timeout.
`timescale 1ns/1ps
`include "dia_consts.vh"

module dia_tw_monitor #(
   parameter PHASE_TO_CYC = `DIA_PHASE_TO_CYC
) (
   // Clock and reset.
   input wire mclk,
   input wire reset_n,
   // Raw bus pins.
   input wire scl_pin,
   input wire sda_pin,
   // Events.
   output reg start_det,
   output reg stop_det,
   output reg phase_timeout
);

   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg scl_d;
   reg sda_d;
   reg [`DIA_CNT_W-1:0] phase_cnt;

   //==================================================================
   // Two flops per pin, then one more stage to find edges.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl_pin};
         sda_sync <= {sda_sync[0], sda_pin};
         scl_d <= scl_sync[1];
         sda_d <= sda_sync[1];
      end
   end

   //==================================================================
   // Start is SDA falling with SCL high; stop is SDA rising with SCL high.
   // A phase counter restarts on every SCL edge; it overflows only if SCL stalls.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         start_det <= 1'b0;
         stop_det <= 1'b0;
         phase_timeout <= 1'b0;
         phase_cnt <= {`DIA_CNT_W{1'b0}};
      end else begin
         start_det <= scl_sync[1] && scl_d && sda_d && !sda_sync[1];
         stop_det <= scl_sync[1] && scl_d && !sda_d && sda_sync[1];
         phase_timeout <= 1'b0;
         if (scl_sync[1] != scl_d) begin
            phase_cnt <= {`DIA_CNT_W{1'b0}};
         end else if (phase_cnt == PHASE_TO_CYC[`DIA_CNT_W-1:0]) begin
            phase_timeout <= 1'b1;
            phase_cnt <= {`DIA_CNT_W{1'b0}};
         end else begin
            phase_cnt <= phase_cnt + 1'b1;
         end
      end
   end

endmodule

// ### rtl/dia_arbiter.v
// Dual interface access arbiter between the two-wire port and the RF port.
`timescale 1ns/1ps
`include "dia_consts.vh"

module dia_arbiter #(
   parameter START_TO_CYC = `DIA_START_TO_CYC,
   parameter PHASE_TO_CYC = `DIA_PHASE_TO_CYC,
   parameter WR_CYC = `DIA_WR_CYC
) (
   // Clock and reset.
   input wire mclk,
   input wire reset_n,
   // Two-wire pins, asynchronous.
   input wire scl_pin,
   input wire sda_pin,
   // Two-wire command decoder, same clock.
   input wire tw_cmd_valid,
   input wire tw_write_launch,
   // RF front end, same clock.
   input wire rf_cmd_valid,
   input wire rf_write_launch,
   input wire rf_write_done,
   input wire rf_done,
   input wire rf_field,
   // Harvest configuration, same clock.
   input wire [1:0] harvest_voltage_sel,
   input wire [1:0] harvest_current_limit_sel,
   // Arbiter results.
   output reg tw_grant,
   output reg tw_hold,
   output reg rf_grant,
   output reg rf_abort,
   output reg rf_cmd_ignored,
   output reg mem_busy,
   output reg harvest_detect_out,
   output reg rf_activity_out,
   output reg [2:0] harvest_mv_code,
   output reg [1:0] harvest_ilim_code
);

   wire start_det;
   wire stop_det;
   wire phase_timeout;
   reg [2:0] state;
   reg [2:0] next_state;
   reg tw_pending;
   reg [`DIA_CNT_W-1:0] start_cnt;
   reg [`DIA_CNT_W-1:0] wr_cnt;
   wire start_to;
   wire tw_wr_end;

   //==================================================================
   // Bus watcher finds starts, stops and stalled clock phases.
   dia_tw_monitor #(
      .PHASE_TO_CYC(PHASE_TO_CYC)
   ) u_mon (
      .mclk(mclk),
      .reset_n(reset_n),
      .scl_pin(scl_pin),
      .sda_pin(sda_pin),
      .start_det(start_det),
      .stop_det(stop_det),
      .phase_timeout(phase_timeout)
   );

   assign start_to = (start_cnt == START_TO_CYC[`DIA_CNT_W-1:0]);
   assign tw_wr_end = (wr_cnt == WR_CYC[`DIA_CNT_W-1:0]);

   //==================================================================
   // Owner selection. A two-wire command held back by an RF write is
   // remembered in tw_pending so it is served once that write ends.
   always @* begin
      next_state = state;
      case (state)
         `DIA_ST_IDLE: begin
            if (tw_cmd_valid || tw_pending) begin
               next_state = `DIA_ST_TW;
            end else if (rf_cmd_valid) begin
               next_state = `DIA_ST_RF;
            end
         end
         `DIA_ST_TW: begin
            if (start_to || phase_timeout) begin
               next_state = `DIA_ST_IDLE;
            end else if (tw_write_launch) begin
               next_state = `DIA_ST_TW_WR;
            end else if (stop_det) begin
               next_state = `DIA_ST_IDLE;
            end
         end
         `DIA_ST_TW_WR: begin
            if (tw_wr_end) begin
               next_state = `DIA_ST_IDLE;
            end
         end
         `DIA_ST_RF: begin
            if (tw_cmd_valid) begin
               next_state = `DIA_ST_TW;
            end else if (rf_write_launch) begin
               next_state = `DIA_ST_RF_WR;
            end else if (rf_done) begin
               next_state = `DIA_ST_IDLE;
            end
         end
         `DIA_ST_RF_WR: begin
            if (rf_write_done) begin
               next_state = `DIA_ST_IDLE;
            end
         end
         default: next_state = `DIA_ST_IDLE;
      endcase
   end

   //==================================================================
   // State, timers and registered outputs.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state <= `DIA_ST_IDLE;
         tw_pending <= 1'b0;
         start_cnt <= {`DIA_CNT_W{1'b0}};
         wr_cnt <= {`DIA_CNT_W{1'b0}};
         tw_grant <= 1'b0;
         tw_hold <= 1'b0;
         rf_grant <= 1'b0;
         rf_abort <= 1'b0;
         rf_cmd_ignored <= 1'b0;
         mem_busy <= 1'b0;
         harvest_detect_out <= 1'b0;
         rf_activity_out <= 1'b0;
         harvest_mv_code <= 3'h0;
         harvest_ilim_code <= 2'h0;
      end else begin
         state <= next_state;
         // Held two-wire command during RF write stays unanswered.
         if (state == `DIA_ST_RF_WR && tw_cmd_valid) begin
            tw_pending <= 1'b1;
         end else if (next_state == `DIA_ST_TW) begin
            tw_pending <= 1'b0;
         end
         // Start timeout counts from the transaction's start.
         if (state != `DIA_ST_TW || start_det) begin
            start_cnt <= {`DIA_CNT_W{1'b0}};
         end else if (!start_to) begin
            start_cnt <= start_cnt + 1'b1;
         end
         if (state != `DIA_ST_TW_WR) begin
            wr_cnt <= {`DIA_CNT_W{1'b0}};
         end else begin
            wr_cnt <= wr_cnt + 1'b1;
         end
         tw_grant <= (next_state == `DIA_ST_TW);
         tw_hold <= (next_state == `DIA_ST_RF_WR) && (tw_pending || tw_cmd_valid);
         rf_grant <= (next_state == `DIA_ST_RF) || (next_state == `DIA_ST_RF_WR);
         // Abort only before the RF write launches, so memory is untouched.
         rf_abort <= (state == `DIA_ST_RF) && tw_cmd_valid;
         rf_cmd_ignored <= rf_cmd_valid && (state == `DIA_ST_TW || state == `DIA_ST_TW_WR);
         mem_busy <= (next_state == `DIA_ST_TW_WR) || (next_state == `DIA_ST_RF_WR);
         harvest_detect_out <= rf_field;
         rf_activity_out <= (next_state == `DIA_ST_RF) || (next_state == `DIA_ST_RF_WR);
         // Code is the rank of the selected level, lowest voltage first, so its top bit stays zero.
         case (harvest_voltage_sel)
            `DIA_EHV_1V5: harvest_mv_code <= 3'h0;
            `DIA_EHV_1V8: harvest_mv_code <= 3'h1;
            `DIA_EHV_2V5: harvest_mv_code <= 3'h2;
            `DIA_EHV_3V3: harvest_mv_code <= 3'h3;
            default: harvest_mv_code <= 3'h0;
         endcase
         harvest_ilim_code <= harvest_current_limit_sel;
      end
   end

endmodule

// ### dv/dia_tw_master.sv
// Two-wire bus master model that frames start and stop conditions.
`timescale 1ns/1ps
module dia_tw_master (
   // Bus pins.
   output logic scl,
   output logic sda
);
   //==========================================
   // Bus conditions
   logic run = 1'b0;
   // Idle lines sit high, as the pull-ups leave them.
   initial {scl, sda} = 2'h3;
   // The link clock runs only inside a frame started with r set; there its phases stay far below the timeout.
   always #80 if (run) scl = ~scl;
   // One half period of the 160 ns link clock, then new levels.
   task automatic drv(input logic c, input logic d);
      #80;
      {scl, sda} = {c, d};
   endtask
   // Start: data falls while the clock is high; r lets the clock run on.
   task automatic start_cond(input logic r);
      drv(1'b1, 1'b0);
      drv(1'b0, 1'b0);
      run = r;
   endtask
   // Stop: data rises while the clock is high.
   task automatic stop_cond();
      run = 1'b0;
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask
endmodule

// ### dv/dia_arbiter_properties.sv
// Port checker for the access arbiter, bound to every instance.
`timescale 1ns/1ps
module dia_arbiter_properties #(
   parameter WR_CYC = 50
) (
   // Clock, reset and requests.
   input wire mclk, reset_n, tw_cmd_valid, rf_cmd_valid, rf_write_launch, rf_write_done, rf_field,
   input wire [1:0] harvest_voltage_sel,
   // Results.
   input wire tw_grant, tw_hold, rf_grant, rf_abort, rf_cmd_ignored, mem_busy, harvest_detect_out,
   input wire [2:0] harvest_mv_code
);
   //==========================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire free = !tw_grant && !tw_hold && !rf_grant && !mem_busy;
   wire rf_cmd_st = rf_grant && !mem_busy;
   int busy_n;
   // Busy run length, judged when the run ends so short and long writes both show.
   always @(posedge mclk or negedge reset_n)
      if (!reset_n) busy_n <= 0;
      else busy_n <= mem_busy ? busy_n + 1 : 0;
   a_tw_wins_tie: assert property (free && tw_cmd_valid && rf_cmd_valid |=> tw_grant && !rf_grant)
      else $error("tie not won by two-wire port");
   a_rf_ignored: assert property (tw_grant && rf_cmd_valid |=> rf_cmd_ignored && !rf_grant)
      else $error("rf command not ignored");
   a_rf_aborted: assert property (rf_cmd_st && !rf_write_launch && tw_cmd_valid |=> rf_abort && tw_grant)
      else $error("rf command not aborted");
   a_tw_held: assert property (rf_grant && mem_busy && tw_cmd_valid && !rf_write_done |=>
      tw_hold && !tw_grant)
      else $error("two-wire not held");
   a_hold_served: assert property (tw_hold && rf_write_done |=> ##1 tw_grant)
      else $error("held command not served");
   // A two-wire write is the busy run with the RF grant low; the RF grant drops with the busy flag as an RF write ends.
   a_tw_write_len: assert property ($fell(mem_busy) && !$past(rf_grant) |-> busy_n == WR_CYC + 1)
      else $error("write cycle length wrong");
   // The first edge after reset still shows reset values, so both checks skip it.
   a_detect_follow: assert property ($past(reset_n) |-> harvest_detect_out == $past(rf_field))
      else $error("field detect wrong");
   a_volt_code: assert property ($past(reset_n) && $stable(harvest_voltage_sel) |->
      harvest_mv_code == {1'b0, $past(harvest_voltage_sel)})
      else $error("voltage code wrong");
   a_abort_no_write: assert property (rf_abort |-> !mem_busy)
      else $error("write during abort");
endmodule
bind dia_arbiter dia_arbiter_properties #(.WR_CYC(WR_CYC)) chk (.mclk, .reset_n, .tw_cmd_valid, .rf_cmd_valid,
   .rf_write_launch, .rf_write_done, .rf_field, .harvest_voltage_sel, .tw_grant, .tw_hold, .rf_grant,
   .rf_abort, .rf_cmd_ignored, .mem_busy, .harvest_detect_out, .harvest_mv_code);

// ### dv/tb.sv
// Table-driven bench for the access arbiter with a two-wire master model.
`timescale 1ns/1ps
module tb;
   //==========================================
   // Signals, counters and steps
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic rf = 1'b0;
   logic [5:0] p = 6'h00;
   logic [3:0] hs = 4'h0;
   logic tw_grant, tw_hold, rf_grant, rf_abort, rf_ign, mem_busy, det, act;
   logic [2:0] mv;
   logic [1:0] il;
   wire scl, sda;
   wire [5:0] o = {rf_ign, rf_abort, tw_grant, tw_hold, rf_grant, mem_busy};
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   // Step: bus action, wait, request pulses, harvest selects, expected results.
   // Bus action 1 frames a start, 3 a start with the clock running on, 2 a stop.
   logic [31:0] st [26] = '{
      32'h0_00_00_0_00, 32'h1_00_14_1_08, 32'h0_00_04_2_28, 32'h2_00_00_3_00,
      32'h0_00_04_4_02, 32'h1_00_10_5_18, 32'h2_00_00_6_00,
      32'h0_00_04_7_02, 32'h0_00_02_8_03, 32'h1_00_10_9_07, 32'h0_00_01_a_00, 32'h0_00_00_b_08, 32'h2_00_00_c_00,
      32'h1_00_10_d_08, 32'h0_00_08_e_01, 32'h0_30_00_f_01, 32'h0_00_00_0_00, 32'h2_00_00_0_00,
      32'h1_00_10_5_08, 32'h0_55_00_a_08, 32'h0_0f_00_5_00, 32'h2_00_00_0_00,
      32'h3_00_10_f_08, 32'h0_be_00_0_08, 32'h0_0c_00_3_00, 32'h2_00_00_0_00};
   // Clock, and a ceiling on the run in case a wait hangs.
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         report_and_stop();
      end
   end
   dia_arbiter #(.START_TO_CYC(200), .PHASE_TO_CYC(100), .WR_CYC(50)) uut (
      .mclk(mclk), .reset_n(reset_n), .scl_pin(scl), .sda_pin(sda), .tw_cmd_valid(p[4]),
      .tw_write_launch(p[3]), .rf_cmd_valid(p[2]), .rf_write_launch(p[1]), .rf_write_done(p[0]),
      .rf_done(p[5]), .rf_field(rf), .harvest_voltage_sel(hs[3:2]), .harvest_current_limit_sel(hs[1:0]),
      .tw_grant(tw_grant), .tw_hold(tw_hold), .rf_grant(rf_grant), .rf_abort(rf_abort),
      .rf_cmd_ignored(rf_ign), .mem_busy(mem_busy), .harvest_detect_out(det), .rf_activity_out(act),
      .harvest_mv_code(mv), .harvest_ilim_code(il));
   dia_tw_master m (.scl(scl), .sda(sda));
   // Case-equal compare; a mismatch is printed and counted at once.
   task automatic ck(input logic [5:0] g, input logic [5:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Counts, verdict and end of run.
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Reset, then every step; pulses last one cycle and are answered one cycle later.
   initial begin
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      rf <= 1'b1;
      foreach (st[k]) begin
         if (st[k][28]) m.start_cond(st[k][29]);
         if (st[k][29:28] == 2'h2) begin
            m.stop_cond();
            // The stop needs two synchroniser stages before the watcher can see it.
            repeat (2) @(posedge mclk);
         end
         repeat (st[k][27:20]) @(posedge mclk);
         @(posedge mclk);
         p <= st[k][17:12];
         hs <= st[k][11:8];
         @(posedge mclk);
         p <= 6'h00;
         #1;
         ck(o, st[k][5:0]);
         ck({1'b0, mv, il}, {2'h0, st[k][11:8]});
         $display("step %0d done", k);
      end
      // Field loss and RF ownership show on their pins one cycle after they are taken.
      @(posedge mclk);
      rf <= 1'b0;
      p <= 6'h04;
      @(posedge mclk);
      p <= 6'h00;
      #1;
      ck({4'h0, det, act}, 6'h01);
      // An RF command that ends without a write frees the memory again.
      @(posedge mclk);
      p <= 6'h20;
      @(posedge mclk);
      p <= 6'h00;
      #1;
      ck({det, act, o[3:0]}, 6'h00);
      // The master looks at the RF activity pin first and only sends when it is quiet.
      wait (!act);
      @(posedge mclk);
      p <= 6'h10;
      @(posedge mclk);
      p <= 6'h00;
      #1;
      ck({det, act, o[3:0]}, 6'h08);
      $display("field test done");
      // A reset while the two-wire port owns the memory clears it; the first edge after only follows the field.
      @(posedge mclk);
      reset_n <= 1'b0;
      rf <= 1'b1;
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      #1;
      ck({det, act, o[3:0]}, 6'h00);
      @(posedge mclk);
      #1;
      ck({det, act, o[3:0]}, 6'h20);
      $display("reset test done");
      report_and_stop();
   end
endmodule
